// ### eeprom_serial_read_ops_test.sv
// Purpose: Runs every read kind and both lock checks across the link
// Assumes: Short quarter count keeps the run brief
// Notes: Target reset outlasts controller reset so the serial clock runs
`timescale 1ns/100ps
`include "esr_defs.svh"
module eeprom_serial_read_ops_test;
  localparam int Q = 4;
  localparam logic [127:0] UidVal = 128'h8899aabbccddeeff0011223344556677;
  localparam logic [127:0] SecVal = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
  localparam logic [7:0] Seed = 8'h3c;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rstTgt = 1'b1;
  logic cmdValid = 1'b0;
  esr_pkg::esr_op_type cmdOp = esr_pkg::ESR_OP_CUR;
  logic [9:0] cmdAddr = 10'h000;
  logic [7:0] cmdLen = 8'h01;
  logic sectorLocked = 1'b0;
  logic cmdReady;
  logic rdValid;
  logic done;
  logic doneNack;
  logic standby;
  logic [7:0] rdData;
  logic [7:0] got [$];
  int error_cnt = 0;
  int compares = 0;
  esr_link link();
  esr_controller #(.QUARTER_CYCLES(`ESR_QCNT_W'(Q))) i_esr_controller (
    .clk(clk), .rst(rst), .bus(link.ctrl), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAddr(cmdAddr), .cmdLen(cmdLen), .cmdReady(cmdReady), .rdData(rdData),
    .rdValid(rdValid), .done(done), .doneNack(doneNack));
  esr_target #(.UID_VALUE(UidVal), .SECTOR_VALUE(SecVal), .FILL_SEED(Seed)) i_esr_target (
    .clk(clk), .rst(rstTgt), .bus(link.tgt), .sectorLocked(sectorLocked), .standby(standby));
  esr_checker #(.QUARTER_CYCLES(Q)) i_esr_checker (
    .clk(clk), .rst(rstTgt), .scl(link.scl), .ctrlSdaOut(link.ctrlSdaOut),
    .ctrlSdaOeN(link.ctrlSdaOeN), .tgtSdaOut(link.tgtSdaOut), .tgtSdaOeN(link.tgtSdaOeN),
    .sda(link.sda));
  always #12.5 clk = ~clk;
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] mainByte(input logic [9:0] p);
    return p[7:0] ^ {6'h00, p[9:8]} ^ Seed;
  endfunction
  task automatic run(input esr_pkg::esr_op_type op, input logic [9:0] a, input int n,
                     input logic expNack);
    int t;
    logic busy;
    busy = 1'b0;
    got.delete();
    for (t = 0; t < 1000 && cmdReady !== 1'b1; t++) @(negedge clk);
    cmdOp = op;
    cmdAddr = a;
    cmdLen = 8'(n);
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    for (t = 0; t < 20000 && done !== 1'b1; t++) begin
      @(negedge clk);
      if (rdValid === 1'b1) got.push_back(rdData);
      if (standby === 1'b0) busy = 1'b1;
    end
    // A hang must not pass on a stale flag, so done itself is checked
    check({6'h00, done, doneNack}, {6'h00, 1'b1, expNack});
    check({7'h00, busy}, 8'h01);
    // Standby lags the stop by a serial fall and a resync
    for (t = 0; t < 200 && standby !== 1'b1; t++) @(negedge clk);
    check({7'h00, standby}, 8'h01);
  endtask
  task automatic expect_bytes(input esr_pkg::esr_op_type op, input logic [9:0] a, input int n);
    logic [7:0] e;
    int i;
    check(8'(got.size()), 8'(n));
    for (int k = 0; k < n; k++) begin
      i = (int'(a[3:0]) + k) % 16;
      case (op)
        esr_pkg::ESR_OP_UID: e = UidVal[8 * i +: 8];
        esr_pkg::ESR_OP_SEC: e = SecVal[8 * i +: 8];
        esr_pkg::ESR_OP_LOCK: e = {6'h00, sectorLocked, 1'b0};
        default: e = mainByte(a + 10'(k));
      endcase
      check(got[k], e);
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (20 * Q) @(negedge clk);
    rstTgt = 1'b0;
    repeat (8 * Q) @(negedge clk);
    run(esr_pkg::ESR_OP_RAND, 10'h3fe, 4, 1'b0);
    expect_bytes(esr_pkg::ESR_OP_RAND, 10'h3fe, 4);
    run(esr_pkg::ESR_OP_CUR, 10'h000, 2, 1'b0);
    expect_bytes(esr_pkg::ESR_OP_CUR, 10'h002, 2);
    run(esr_pkg::ESR_OP_UID, 10'h00e, 4, 1'b0);
    expect_bytes(esr_pkg::ESR_OP_UID, 10'h00e, 4);
    run(esr_pkg::ESR_OP_SEC, 10'h00f, 3, 1'b0);
    expect_bytes(esr_pkg::ESR_OP_SEC, 10'h00f, 3);
    for (int k = 0; k < 2; k++) begin
      sectorLocked = k[0];
      run(esr_pkg::ESR_OP_LOCK, 10'h000, 3, 1'b0);
      expect_bytes(esr_pkg::ESR_OP_LOCK, 10'h000, 3);
      run(esr_pkg::ESR_OP_PROBE, 10'h003, 1, k[0]);
    end
    // Truncated probe must leave a plain read intact
    run(esr_pkg::ESR_OP_RAND, 10'h155, 1, 1'b0);
    expect_bytes(esr_pkg::ESR_OP_RAND, 10'h155, 1);
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule

// ### esr_checker.sv
// Purpose: Watches the serial link where controller and target meet
// Assumes: Sampled on the controller clock, far faster than the serial clock
// Notes: Helper logic tracks start, stop and bit position of each byte
`timescale 1ns/100ps
module esr_checker #(
  parameter int QUARTER_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic ctrlSdaOut,
  input wire logic ctrlSdaOeN,
  input wire logic tgtSdaOut,
  input wire logic tgtSdaOeN,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic first_q;
  logic rdMode_q;
  logic idle_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [11:0] run_q;
  logic rise;
  logic startSeen;
  logic stopSeen;
  logic addrOk;
  assign rise = scl & ~scl_q;
  assign startSeen = scl & scl_q & sda_q & ~sda;
  assign stopSeen = scl & scl_q & ~sda_q & sda;
  assign addrOk = (shift_q[7:5] == 3'h5) & ~shift_q[3];
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    run_q <= (rst || scl != scl_q) ? 12'h000 : run_q + 12'h001;
    if (rst || startSeen) begin
      bitCnt_q <= 4'h0;
      first_q <= 1'b1;
      idle_q <= rst;
      rdMode_q <= 1'b0;
    end else if (stopSeen) begin
      idle_q <= 1'b1;
    end else if (rise) begin
      bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
      if (bitCnt_q != 4'h8) shift_q <= {shift_q[6:0], sda};
      if (bitCnt_q == 4'h8) first_q <= 1'b0;
      if (bitCnt_q == 4'h7 && first_q) rdMode_q <= sda;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence ninthRise;
    rise && bitCnt_q == 4'h8;
  endsequence
  a_open_drain: assert property (!ctrlSdaOut && !tgtSdaOut)
    else $error("data driver drives high");
  a_tgt_stable: assert property (scl && scl_q |-> $stable(tgtSdaOeN))
    else $error("target moved data while clock high");
  a_addr_ack: assert property (ninthRise ##0 (first_q && addrOk) |-> !tgtSdaOeN)
    else $error("valid device address not acknowledged");
  a_restart_free: assert property (rise && first_q && bitCnt_q != 4'h8 |-> tgtSdaOeN)
    else $error("target drives during address byte");
  a_rd_release: assert property (
    rise && !first_q && rdMode_q && bitCnt_q inside {[4'h1:4'h7]} |-> ctrlSdaOeN)
    else $error("controller drives during read data");
  a_host_ack_free: assert property (ninthRise ##0 (!first_q && rdMode_q) |-> tgtSdaOeN)
    else $error("target holds data in host acknowledge slot");
  a_idle_release: assert property (idle_q |-> tgtSdaOeN)
    else $error("target drives after stop");
  a_start_owner: assert property (startSeen |-> !ctrlSdaOeN && tgtSdaOeN)
    else $error("start not made by controller alone");
  a_scl_half: assert property (run_q < 12'(2 * QUARTER_CYCLES))
    else $error("serial clock half period too long");
endmodule

// ### esr_controller.sv
// Purpose: Controller end that runs reads and lock probes on the link
// Assumes: Serial clock divided from clk, running free
// Notes: Bits change at quarter one, sampled at quarter three
`timescale 1ns/100ps
`include "esr_defs.svh"
module esr_controller #(
  parameter logic [`ESR_QCNT_W-1:0] QUARTER_CYCLES = `ESR_QCNT_W'(`ESR_QUARTER_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  esr_link.ctrl bus,
  input wire logic cmdValid,
  input wire esr_pkg::esr_op_type cmdOp,
  input wire logic [`ESR_PTR_W-1:0] cmdAddr,
  input wire logic [7:0] cmdLen,
  output logic cmdReady,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic done,
  output logic doneNack
);
  esr_pkg::esr_ctrl_type state_q;
  esr_pkg::esr_ctrl_type state_d;
  logic tick;
  logic [1:0] nextPh;
  logic drivePt;
  logic samplePt;
  logic ack;
  logic probe;

  function automatic logic [7:0] dev_byte(
    input esr_pkg::esr_op_type op,
    input logic [`ESR_PTR_W-1:0] a,
    input logic rd
  );
    logic [3:0] nib;
    nib = (op == esr_pkg::ESR_OP_CUR || op == esr_pkg::ESR_OP_RAND) ?
          `ESR_DEV_MAIN : `ESR_DEV_SPECIAL;
    return {nib, 1'b0, a[9:8], rd}; // RULE1 RULE22 RULE23
  endfunction

  function automatic logic [7:0] word_byte(
    input esr_pkg::esr_op_type op,
    input logic [`ESR_PTR_W-1:0] a
  );
    logic [7:0] w;
    w = a[7:0];
    unique case (op)
      esr_pkg::ESR_OP_UID: w = {`ESR_WORD_UID, 2'h0, a[3:0]}; // RULE11
      esr_pkg::ESR_OP_SEC: w = {`ESR_WORD_SEC, 2'h0, a[3:0]}; // RULE13
      esr_pkg::ESR_OP_PROBE: w = {`ESR_WORD_SEC, 2'h0, a[3:0]};
      esr_pkg::ESR_OP_LOCK: w = `ESR_LOCK_WORD; // RULE19
      default: w = a[7:0];
    endcase
    return w;
  endfunction

  assign tick = (state_q.qCnt == QUARTER_CYCLES - `ESR_QCNT_W'(1));
  assign nextPh = state_q.phase + 2'h1;
  assign drivePt = tick & (nextPh == 2'h1);
  assign samplePt = tick & (nextPh == 2'h3);
  assign ack = ~state_q.sdaS2;
  assign probe = (state_q.op == esr_pkg::ESR_OP_PROBE);

  always_comb begin
    state_d = state_q;
    state_d.sdaS1 = bus.sda;
    state_d.sdaS2 = state_q.sdaS1;
    state_d.rdValid = 1'b0;
    state_d.done = 1'b0;
    state_d.qCnt = tick ? '0 : state_q.qCnt + `ESR_QCNT_W'(1);
    if (tick) begin
      state_d.phase = nextPh;
      state_d.sclOut = nextPh[1];
    end
    unique case (state_q.st)
      esr_pkg::ESR_H_IDLE: begin
        state_d.cmdReady = 1'b1;
        state_d.sdaOeN = 1'b1;
        if (cmdValid && state_q.cmdReady) begin
          state_d.cmdReady = 1'b0;
          state_d.op = cmdOp;
          state_d.addr = cmdAddr;
          state_d.remain = (cmdLen == 8'h00) ? 8'h01 : cmdLen;
          state_d.step = 2'h0;
          state_d.abandon = 1'b0;
          state_d.nack = 1'b0;
          state_d.st = esr_pkg::ESR_H_START;
        end
      end
      esr_pkg::ESR_H_START: begin
        if (drivePt) begin
          state_d.sdaOeN = 1'b1;
        end else if (samplePt) begin
          state_d.sdaOeN = 1'b0;
          state_d.bitCnt = 4'h0;
          state_d.shift = dev_byte(state_q.op, state_q.addr,
            !probe && (state_q.op == esr_pkg::ESR_OP_CUR || state_q.step == 2'h2));
          state_d.st = state_q.abandon ? esr_pkg::ESR_H_STOP : esr_pkg::ESR_H_TX; // RULE16
        end
      end
      esr_pkg::ESR_H_TX: begin
        if (drivePt) begin
          state_d.sdaOeN = state_q.bitCnt[3] | state_q.shift[7];
        end else if (samplePt && !state_q.bitCnt[3]) begin
          state_d.shift = {state_q.shift[6:0], 1'b0};
          state_d.bitCnt = state_q.bitCnt + 4'h1;
        end else if (samplePt) begin
          state_d.bitCnt = 4'h0;
          if (probe && state_q.step == 2'h2) begin
            // Lock state read from the data acknowledge, then abandon
            state_d.nack = ~ack; // RULE15 RULE16
            state_d.abandon = 1'b1;
            state_d.st = esr_pkg::ESR_H_START;
          end else if (!ack) begin
            state_d.nack = 1'b1;
            state_d.st = esr_pkg::ESR_H_STOP;
          end else if (state_q.op == esr_pkg::ESR_OP_CUR || state_q.step == 2'h2) begin
            state_d.st = esr_pkg::ESR_H_RX;
          end else if (state_q.step == 2'h0) begin
            state_d.shift = word_byte(state_q.op, state_q.addr);
            state_d.step = 2'h1;
          end else if (probe) begin
            state_d.shift = 8'h00;
            state_d.step = 2'h2;
          end else begin
            state_d.step = 2'h2;
            state_d.st = esr_pkg::ESR_H_START; // RULE7
          end
        end
      end
      esr_pkg::ESR_H_RX: begin
        if (drivePt) begin
          // Last byte gets no acknowledge so the target lets go
          state_d.sdaOeN = ~state_q.bitCnt[3] | (state_q.remain == 8'h01); // RULE6 RULE10
        end else if (samplePt && !state_q.bitCnt[3]) begin
          state_d.shift = {state_q.shift[6:0], state_q.sdaS2};
          state_d.bitCnt = state_q.bitCnt + 4'h1;
          if (state_q.bitCnt == 4'h7) begin
            state_d.rdData = {state_q.shift[6:0], state_q.sdaS2};
            state_d.rdValid = 1'b1;
          end
        end else if (samplePt) begin
          state_d.bitCnt = 4'h0;
          if (state_q.remain != 8'h01) begin
            state_d.remain = state_q.remain - 8'h01;
          end else begin
            state_d.st = esr_pkg::ESR_H_STOP;
          end
        end
      end
      esr_pkg::ESR_H_STOP: begin
        if (drivePt) begin
          state_d.sdaOeN = 1'b0;
        end else if (samplePt) begin
          state_d.sdaOeN = 1'b1;
          state_d.done = 1'b1;
          state_d.doneNack = state_q.nack;
          state_d.st = esr_pkg::ESR_H_IDLE;
        end
      end
      default: begin
        state_d.st = esr_pkg::ESR_H_IDLE;
      end
    endcase
    state_d.sdaOut = 1'b0;
    if (rst) begin
      state_d = '0;
      state_d.sdaS1 = 1'b1;
      state_d.sdaS2 = 1'b1;
      state_d.sdaOeN = 1'b1;
      state_d.st = esr_pkg::ESR_H_IDLE;
      state_d.op = esr_pkg::ESR_OP_CUR;
    end
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  assign bus.scl = state_q.sclOut;
  assign bus.ctrlSdaOut = state_q.sdaOut;
  assign bus.ctrlSdaOeN = state_q.sdaOeN;
  assign cmdReady = state_q.cmdReady;
  assign rdData = state_q.rdData;
  assign rdValid = state_q.rdValid;
  assign done = state_q.done;
  assign doneNack = state_q.doneNack;
endmodule

// ### esr_defs.svh
// Purpose: Shared constants for the serial EEPROM read link
// Assumes: 40 MHz controller clock, 100 kHz serial clock
// Notes: Counts derive from times; times keep their own units
// Function
// RULE1 - Read starts like write, direction bit one
// RULE2 - Pointer holds last address plus one
// RULE3 - Read pointer wraps from array end to start
// RULE4 - Write pointer wraps inside current page
// RULE5 - Current read outputs byte at pointer
// RULE6 - Controller ends single read with nack, stop
// RULE7 - Random read: dummy write, restart, read address
// RULE8 - Random read outputs byte at loaded address
// RULE9 - Acked bytes advance pointer, sequential read continues
// RULE10 - Nack then stop ends read; release data
// RULE11 - Identifier word address bits 7:6 are 10b
// RULE12 - Identifier read wraps after sixteen bytes
// RULE13 - Sector word address bits 7:6 are 00b
// RULE14 - Sector index wraps 0Fh to 00h
// RULE15 - Sector write acked only while unlocked
// RULE16 - Controller abandons probe with start then stop
// RULE17 - Start mid-command resets protocol logic
// RULE18 - Stop returns device to standby
// RULE19 - Lock status word address bit 6 one
// RULE20 - Status bit 1 shows lock state
// RULE21 - Status byte repeats until nack and stop
// RULE22 - Main address: 1010, zero, page bits, direction
// RULE23 - Special areas use device nibble 1011
// RULE24 - Device acks by pulling data low, ninth clock
`ifndef ESR_DEFS_SVH
`define ESR_DEFS_SVH
`define ESR_DEV_MAIN 4'ha
`define ESR_DEV_SPECIAL 4'hb
`define ESR_LOCK_BIT 1
`define ESR_PTR_W 10
`define ESR_IDX_W 4
`define ESR_PTR_RST 10'h000
`define ESR_WORD_LOCK_BIT 6
`define ESR_WORD_UID 2'h2
`define ESR_WORD_SEC 2'h0
`define ESR_LOCK_WORD 8'h40
`define ESR_SCL_PERIOD_NS 10000
`define ESR_CLK_PERIOD_NS 25
`define ESR_QUARTER_CYC (((`ESR_SCL_PERIOD_NS / 4) + `ESR_CLK_PERIOD_NS - 1) / `ESR_CLK_PERIOD_NS)
`define ESR_QCNT_W 12
`endif

// ### esr_edge_capture.sv
// Purpose: Holds the data line level seen at each serial clock rise
// Assumes: Reset already synchronised to the serial clock
// Notes: Compared against the fall sample to spot start and stop
`timescale 1ns/100ps
module esr_edge_capture (
  input wire logic scl,
  input wire logic rstSync,
  input wire logic sdaIn,
  output logic sdaAtRise
);
  logic state_q;
  logic state_d;

  always_comb begin
    state_d = rstSync ? 1'b1 : sdaIn;
  end

  always_ff @(posedge scl) begin
    state_q <= state_d;
  end

  assign sdaAtRise = state_q;
endmodule

// ### esr_link.sv
// Purpose: Two-wire link between controller and target
// Assumes: Both data drivers are open-drain style
// Notes: Line level resolved here from the enables
`timescale 1ns/100ps
interface esr_link;
  logic scl;
  logic ctrlSdaOut;
  logic ctrlSdaOeN;
  logic tgtSdaOut;
  logic tgtSdaOeN;
  logic sda;
  // Pulled high unless an enabled driver sinks it
  assign sda = ~((~ctrlSdaOeN & ~ctrlSdaOut) | (~tgtSdaOeN & ~tgtSdaOut));
  modport ctrl (output scl, output ctrlSdaOut, output ctrlSdaOeN, input sda);
  modport tgt (input scl, input sda, output tgtSdaOut, output tgtSdaOeN);
endinterface

// ### esr_pkg.sv
// Purpose: Types shared by both ends of the serial EEPROM link
// Assumes: Constants come from the defs header
// Notes: Controller state sits in one packed struct; the target splits its state across two, one per clock
`include "esr_defs.svh"
package esr_pkg;
  typedef enum logic [2:0] {
    ESR_D_IDLE = 3'h0, ESR_D_ADDR = 3'h1, ESR_D_WORD = 3'h2,
    ESR_D_WDATA = 3'h3, ESR_D_RDATA = 3'h4
  } esr_dstate_type;
  typedef enum logic [1:0] {
    ESR_A_MAIN = 2'h0, ESR_A_UID = 2'h1, ESR_A_SEC = 2'h2, ESR_A_LOCK = 2'h3
  } esr_area_type;
  typedef enum logic [2:0] {
    ESR_OP_CUR = 3'h0, ESR_OP_RAND = 3'h1, ESR_OP_UID = 3'h2,
    ESR_OP_SEC = 3'h3, ESR_OP_LOCK = 3'h4, ESR_OP_PROBE = 3'h5
  } esr_op_type;
  typedef enum logic [2:0] {
    ESR_H_IDLE = 3'h0, ESR_H_START = 3'h1, ESR_H_TX = 3'h2,
    ESR_H_RX = 3'h3, ESR_H_STOP = 3'h4
  } esr_hstate_type;
  typedef struct packed {
    logic rstS1;
    logic rstS2;
    logic lockS1;
    logic lockS2;
    esr_dstate_type st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic spec;
    logic [1:0] pageSelectBits;
    esr_area_type spArea;
    logic [`ESR_PTR_W-1:0] ptr;
    logic [`ESR_IDX_W-1:0] idx;
    logic sdaOeN;
    logic sdaOut;
    logic idleFlag;
  } esr_tgt_type;
  typedef struct packed {
    logic s1;
    logic s2;
  } esr_tgt_clk_type;
  typedef struct packed {
    logic [`ESR_QCNT_W-1:0] qCnt;
    logic [1:0] phase;
    logic sclOut;
    logic sdaS1;
    logic sdaS2;
    logic sdaOeN;
    logic sdaOut;
    esr_hstate_type st;
    esr_op_type op;
    logic [`ESR_PTR_W-1:0] addr;
    logic [7:0] remain;
    logic [1:0] step;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic abandon;
    logic nack;
    logic [7:0] rdData;
    logic rdValid;
    logic done;
    logic doneNack;
    logic cmdReady;
  } esr_ctrl_type;
endpackage

// ### esr_target.sv
// Purpose: Target end of the serial EEPROM read link
// Assumes: Controller keeps the serial clock running between frames
// Notes: Array and sector contents are fixed patterns; writes are not stored
`timescale 1ns/100ps
`include "esr_defs.svh"
module esr_target #(
  parameter logic [127:0] UID_VALUE = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0,
  parameter logic [127:0] SECTOR_VALUE = 128'h00112233445566778899aabbccddeeff,
  parameter logic [7:0] FILL_SEED = 8'h5a
) (
  input wire logic clk,
  input wire logic rst,
  esr_link.tgt bus,
  input wire logic sectorLocked,
  output logic standby
);
  esr_pkg::esr_tgt_type state_q;
  esr_pkg::esr_tgt_type state_d;
  esr_pkg::esr_tgt_clk_type sync_q;
  esr_pkg::esr_tgt_clk_type sync_d;
  esr_pkg::esr_area_type area;
  logic sdaAtRise;
  logic startSeen;
  logic stopSeen;
  logic doLoad;
  logic wrAck;
  logic [7:0] byteIn;
  logic [7:0] curByte;

  // Stand-in array contents, since this block holds no cell array
  function automatic logic [7:0] read_byte(
    input esr_pkg::esr_area_type a,
    input logic [`ESR_PTR_W-1:0] p,
    input logic [`ESR_IDX_W-1:0] i,
    input logic locked
  );
    logic [7:0] b;
    b = 8'h00;
    unique case (a)
      esr_pkg::ESR_A_MAIN: b = p[7:0] ^ {6'h00, p[9:8]} ^ FILL_SEED;
      esr_pkg::ESR_A_UID: b = UID_VALUE[{i, 3'h0} +: 8];
      esr_pkg::ESR_A_SEC: b = SECTOR_VALUE[{i, 3'h0} +: 8];
      esr_pkg::ESR_A_LOCK: begin
        b = 8'h00;
        b[`ESR_LOCK_BIT] = locked; // RULE20
      end
    endcase
    return b;
  endfunction

  esr_edge_capture u_edge (
    .scl(bus.scl),
    .rstSync(state_q.rstS2),
    .sdaIn(bus.sda),
    .sdaAtRise(sdaAtRise)
  );

  assign area = state_q.spec ? state_q.spArea : esr_pkg::ESR_A_MAIN;
  assign curByte = read_byte(area, state_q.ptr, state_q.idx, state_q.lockS2);
  // Data only changes with the clock low, so a change while high is a condition
  assign startSeen = sdaAtRise & ~bus.sda;
  assign stopSeen = ~sdaAtRise & bus.sda;
  assign byteIn = {state_q.shift[6:0], bus.sda};
  // Identifier never takes data; sector and lock writes only while unlocked
  assign wrAck = (area == esr_pkg::ESR_A_MAIN) |
                 ((area != esr_pkg::ESR_A_UID) & ~state_q.lockS2);

  always_comb begin
    state_d = state_q;
    state_d.rstS1 = rst;
    state_d.rstS2 = state_q.rstS1;
    state_d.lockS1 = sectorLocked;
    state_d.lockS2 = state_q.lockS1;
    doLoad = 1'b0;
    if (state_q.rstS2) begin
      state_d.st = esr_pkg::ESR_D_IDLE;
      state_d.bitCnt = 4'h0;
      state_d.shift = 8'h00;
      state_d.rw = 1'b0;
      state_d.spec = 1'b0;
      state_d.pageSelectBits = 2'h0;
      state_d.spArea = esr_pkg::ESR_A_UID;
      state_d.ptr = `ESR_PTR_RST;
      state_d.idx = 4'h0;
      state_d.sdaOeN = 1'b1;
    end else if (startSeen) begin
      // Any partial command is dropped here
      state_d.st = esr_pkg::ESR_D_ADDR; // RULE17
      state_d.bitCnt = 4'h0;
      state_d.sdaOeN = 1'b1;
    end else if (stopSeen) begin
      state_d.st = esr_pkg::ESR_D_IDLE; // RULE18
      state_d.sdaOeN = 1'b1;
    end else begin
      unique case (state_q.st)
        esr_pkg::ESR_D_IDLE: begin
          state_d.sdaOeN = 1'b1;
        end
        esr_pkg::ESR_D_ADDR: begin
          if (state_q.bitCnt == 4'h7) begin
            if ((byteIn[7:4] == `ESR_DEV_MAIN || byteIn[7:4] == `ESR_DEV_SPECIAL)
                && !byteIn[3]) begin // RULE22 RULE23
              state_d.sdaOeN = 1'b0; // RULE24
              state_d.rw = byteIn[0]; // RULE1
              state_d.spec = byteIn[4];
              state_d.pageSelectBits = byteIn[2:1];
              state_d.bitCnt = 4'h8;
            end else begin
              state_d.st = esr_pkg::ESR_D_IDLE;
            end
          end else if (state_q.bitCnt[3]) begin
            state_d.sdaOeN = 1'b1;
            state_d.bitCnt = 4'h0;
            if (state_q.rw) begin
              state_d.st = esr_pkg::ESR_D_RDATA;
              doLoad = 1'b1; // RULE5 RULE8
            end else begin
              state_d.st = esr_pkg::ESR_D_WORD;
            end
          end else begin
            state_d.shift = byteIn;
            state_d.bitCnt = state_q.bitCnt + 4'h1;
          end
        end
        esr_pkg::ESR_D_WORD: begin
          if (state_q.bitCnt == 4'h7) begin
            state_d.sdaOeN = 1'b0; // RULE24
            state_d.bitCnt = 4'h8;
            if (!state_q.spec) begin
              state_d.ptr = {state_q.pageSelectBits, byteIn};
            end else begin
              state_d.idx = byteIn[3:0];
              if (byteIn[`ESR_WORD_LOCK_BIT]) begin
                state_d.spArea = esr_pkg::ESR_A_LOCK; // RULE19
              end else if (byteIn[7:6] == `ESR_WORD_UID) begin
                state_d.spArea = esr_pkg::ESR_A_UID; // RULE11
              end else begin
                state_d.spArea = esr_pkg::ESR_A_SEC; // RULE13
              end
            end
          end else if (state_q.bitCnt[3]) begin
            state_d.sdaOeN = 1'b1;
            state_d.bitCnt = 4'h0;
            state_d.st = esr_pkg::ESR_D_WDATA;
          end else begin
            state_d.shift = byteIn;
            state_d.bitCnt = state_q.bitCnt + 4'h1;
          end
        end
        esr_pkg::ESR_D_WDATA: begin
          if (state_q.bitCnt == 4'h7) begin
            if (wrAck) begin // RULE15
              state_d.sdaOeN = 1'b0;
              state_d.bitCnt = 4'h8;
              if (area == esr_pkg::ESR_A_MAIN) begin
                state_d.ptr = {state_q.ptr[9:4], state_q.ptr[3:0] + 4'h1}; // RULE4
              end else begin
                state_d.idx = state_q.idx + 4'h1;
              end
            end else begin
              state_d.st = esr_pkg::ESR_D_IDLE;
            end
          end else if (state_q.bitCnt[3]) begin
            state_d.sdaOeN = 1'b1;
            state_d.bitCnt = 4'h0;
          end else begin
            state_d.shift = byteIn;
            state_d.bitCnt = state_q.bitCnt + 4'h1;
          end
        end
        esr_pkg::ESR_D_RDATA: begin
          if (state_q.bitCnt == 4'h7) begin
            state_d.sdaOeN = 1'b1;
            state_d.bitCnt = 4'h8;
          end else if (state_q.bitCnt[3]) begin
            if (!bus.sda) begin
              doLoad = 1'b1; // RULE9 RULE21
              state_d.bitCnt = 4'h0;
            end else begin
              // Release now; the stop that follows only confirms standby
              state_d.st = esr_pkg::ESR_D_IDLE; // RULE10
            end
          end else begin
            state_d.shift = {state_q.shift[6:0], 1'b0};
            state_d.sdaOeN = state_q.shift[6];
            state_d.bitCnt = state_q.bitCnt + 4'h1;
          end
        end
        default: begin
          state_d.st = esr_pkg::ESR_D_IDLE;
          state_d.sdaOeN = 1'b1;
        end
      endcase
    end
    if (doLoad) begin
      state_d.shift = curByte;
      state_d.sdaOeN = curByte[7];
      unique case (area)
        esr_pkg::ESR_A_MAIN: state_d.ptr = state_q.ptr + 10'h001; // RULE2 RULE3
        esr_pkg::ESR_A_UID: state_d.idx = state_q.idx + 4'h1; // RULE12
        esr_pkg::ESR_A_SEC: state_d.idx = state_q.idx + 4'h1; // RULE14
        esr_pkg::ESR_A_LOCK: state_d.idx = state_q.idx;
      endcase
    end
    state_d.sdaOut = 1'b0;
    state_d.idleFlag = (state_d.st == esr_pkg::ESR_D_IDLE);
  end

  // Outputs change on the falling edge so data never moves with the clock high
  always_ff @(negedge bus.scl) begin
    state_q <= state_d;
  end

  always_comb begin
    sync_d.s1 = state_q.idleFlag;
    sync_d.s2 = sync_q.s1;
    if (rst) begin
      sync_d.s1 = 1'b1;
      sync_d.s2 = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    sync_q <= sync_d;
  end

  assign bus.tgtSdaOut = state_q.sdaOut;
  assign bus.tgtSdaOeN = state_q.sdaOeN;
  assign standby = sync_q.s2;
endmodule
